// file: rtl/mec_pkg.sv
// Operation
// R1: Respond only to device code octal 2
// R2: Priority mask never blocks interrupt request
// R3: I/O reset clears request, Done, mode flags; code loads mode 100 instead, leaving flag 13 set
// R4: Flag commands none, clear, pulse do nothing
// R5: Start command clears request and Done
// R6: Input A returns low fault address
// R7: Host reads fault data while Done set
// R8: Input B returns syndrome, zeros, high address
// R9: Zero syndrome no error; check bits one-hot
// R10: Data-bit syndromes follow fixed table
// R11: Output A loads mode from bits 13-15
// R12: Modes 000-011 set write and checking
// R13: Modes 100-111 set write and checking
// R14: Error latches address, syndrome, Done, request
package mec_pkg;

  // Device code of this unit
  localparam logic [5:0] MEC_DEV_CODE = 6'h02;

  // Transfer selects (instruction bits 5-7)
  localparam logic [2:0] MEC_XFER_IN_A  = 3'h1;
  localparam logic [2:0] MEC_XFER_OUT_A = 3'h2;
  localparam logic [2:0] MEC_XFER_IN_B  = 3'h3;

  // Flag command codes (instruction bits 8-9)
  localparam logic [1:0] MEC_FLAG_NONE  = 2'h0;
  localparam logic [1:0] MEC_FLAG_START = 2'h1;

  // Mode field: accumulator bits 13-15 are the low three bits
  localparam int         MEC_MODE_LSB   = 0;
  localparam logic [2:0] MEC_MODE_RESET = 3'h0;
  // Mode left by the I/O reset: flags 14 and 15 clear, checking off,
  // so a stale check result cannot raise Done after the bus reset
  localparam logic [2:0] MEC_MODE_IO_SYSTEM_RESET = 3'h4;

  // Fault code word layout
  localparam int MEC_SYN_LSB   = 10;
  localparam int MEC_HIGH_LSB  = 0;
  localparam int MEC_ADDR_BITS = 20;

  // Syndrome meaning
  typedef enum logic [1:0] {
    MEC_SYN_NONE  = 2'b00,
    MEC_SYN_CHECK = 2'b01,
    MEC_SYN_DATA  = 2'b10,
    MEC_SYN_MULTI = 2'b11
  } mec_syn_kind_type;

endpackage : mec_pkg

// file: rtl/mec_syndrome_decode.sv
// Classifies a six-bit syndrome and names the failing data bit
module mec_syndrome_decode
  import mec_pkg::*;
(
  // Syndrome in
  input  wire logic [5:0]       syndrome,
  // Classification out
  output mec_syn_kind_type      kind,
  output logic      [3:0]       data_bit
);

  // Table lookup; bit 0 of the field is printed leftmost
  always_comb begin
    kind     = MEC_SYN_MULTI;
    data_bit = 4'h0;
    case (syndrome)
      6'h00: kind = MEC_SYN_NONE; // R9
      6'h01, 6'h02, 6'h04,
      6'h08, 6'h10, 6'h20: kind = MEC_SYN_CHECK; // R9
      6'h1C: begin kind = MEC_SYN_DATA; data_bit = 4'h0; end // R10
      6'h34: begin kind = MEC_SYN_DATA; data_bit = 4'h1; end
      6'h32: begin kind = MEC_SYN_DATA; data_bit = 4'h2; end
      6'h2A: begin kind = MEC_SYN_DATA; data_bit = 4'h3; end
      6'h1A: begin kind = MEC_SYN_DATA; data_bit = 4'h4; end
      6'h26: begin kind = MEC_SYN_DATA; data_bit = 4'h5; end
      6'h16: begin kind = MEC_SYN_DATA; data_bit = 4'h6; end
      6'h0E: begin kind = MEC_SYN_DATA; data_bit = 4'h7; end
      6'h31: begin kind = MEC_SYN_DATA; data_bit = 4'h8; end
      6'h29: begin kind = MEC_SYN_DATA; data_bit = 4'h9; end
      6'h19: begin kind = MEC_SYN_DATA; data_bit = 4'hA; end
      6'h25: begin kind = MEC_SYN_DATA; data_bit = 4'hB; end
      6'h15: begin kind = MEC_SYN_DATA; data_bit = 4'hC; end
      6'h0D: begin kind = MEC_SYN_DATA; data_bit = 4'hD; end
      6'h23: begin kind = MEC_SYN_DATA; data_bit = 4'hE; end
      6'h0B: begin kind = MEC_SYN_DATA; data_bit = 4'hF; end
      default: kind = MEC_SYN_MULTI;
    endcase
  end

endmodule : mec_syndrome_decode

// file: rtl/memory_error_corrector.sv
// Error checking and correction control unit on the programmed I/O bus
module memory_error_corrector
  import mec_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Programmed I/O instruction strobe
  input  wire logic        io_strobe,
  input  wire logic [5:0]  io_dev_code,
  input  wire logic [2:0]  io_xfer,
  input  wire logic [1:0]  io_flag_cmd,
  input  wire logic [15:0] io_acc_out,
  input  wire logic        io_system_reset,
  // Priority mask from the processor
  input  wire logic [15:0] io_prio_mask,
  // Checker report from the memory array
  input  wire logic        chk_error,
  input  wire logic        chk_is_refresh,
  input  wire logic [19:0] chk_address,
  input  wire logic [5:0]  chk_syndrome,
  // Read data back to the processor
  output logic      [15:0] io_acc_in,
  output logic             io_acc_valid,
  // Status and control toward the system
  output logic             done_flag,
  output logic             int_request,
  output logic             write_checkcode,
  output logic             check_on_read,
  output logic             check_on_refresh,
  output logic             syn_single_bit
);

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [2:0]  mode_reg,  mode_next;     // Operating mode
  logic        done_reg,  done_next;     // Done flag
  logic        irq_reg,   irq_next;      // Interrupt request flag
  logic [19:0] faddr_reg, faddr_next;    // Captured fault address
  logic [5:0]  fsyn_reg,  fsyn_next;     // Captured syndrome
  logic [15:0] rdata_reg, rdata_next;    // Read data holding
  logic        rval_reg,  rval_next;     // Read data valid pulse
  logic        wcc_reg,   wcc_next;      // Write checkcode
  logic        crd_reg,   crd_next;      // Check on read
  logic        crf_reg,   crf_next;      // Check on refresh
  logic        single_reg, single_next;  // Last fault correctable

  mec_syn_kind_type syn_kind;            // Class of incoming syndrome

  logic hit;                             // Instruction addressed here
  logic err_seen;                        // Checker error in active mode

  ////////////////////////////////////////////////////////////////////////
  // Mode decode helpers
  function automatic logic mode_writes(input logic [2:0] m);
    return !(m == 3'h1 || m == 3'h5); // R12 R13
  endfunction : mode_writes

  function automatic logic mode_irq_on(input logic [2:0] m);
    return (m == 3'h3 || m == 3'h7); // R12 R13
  endfunction : mode_irq_on

  function automatic logic mode_chk_read(input logic [2:0] m);
    return (m[1] == 1'b1); // R12 R13
  endfunction : mode_chk_read

  function automatic logic mode_chk_ref(input logic [2:0] m);
    return (m[2] == 1'b0); // R12 R13
  endfunction : mode_chk_ref

  ////////////////////////////////////////////////////////////////////////
  // Syndrome classification
  mec_syndrome_decode u_decode (
    .syndrome (chk_syndrome),
    .kind     (syn_kind),
    .data_bit ()
  );

  // Only code 2 is served; the mask input is deliberately unused
  // because no mask bit belongs to this unit
  assign hit = io_strobe && (io_dev_code == MEC_DEV_CODE); // R1 R2

  // Errors count only when checking is enabled for that access type
  assign err_seen = chk_error && (chk_syndrome != 6'h00) &&
                    (chk_is_refresh ? crf_reg : crd_reg); // R9 R14

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    mode_next   = mode_reg;
    done_next   = done_reg;
    irq_next    = irq_reg;
    faddr_next  = faddr_reg;
    fsyn_next   = fsyn_reg;
    rdata_next  = rdata_reg;
    rval_next   = 1'b0;
    single_next = single_reg;
    // Error capture; a later error overwrites, matching the last fault
    if (err_seen) begin
      faddr_next  = chk_address; // R14
      fsyn_next   = chk_syndrome;
      single_next = (syn_kind == MEC_SYN_CHECK) ||
                    (syn_kind == MEC_SYN_DATA); // R10
      done_next   = 1'b1; // R14
      if (mode_irq_on(mode_reg)) begin
        irq_next = 1'b1; // R14
      end
    end
    if (hit) begin
      case (io_xfer)
        MEC_XFER_IN_A: begin
          rdata_next = faddr_reg[15:0]; // R6 R7
          rval_next  = 1'b1;
        end
        MEC_XFER_IN_B: begin
          rdata_next = {fsyn_reg, 6'h00, faddr_reg[19:16]}; // R8
          rval_next  = 1'b1;
        end
        MEC_XFER_OUT_A: begin
          mode_next = io_acc_out[MEC_MODE_LSB +: 3]; // R11
        end
        default: begin
        end
      endcase
      // Start clears both flags; other codes do nothing; new error wins
      if (io_flag_cmd == MEC_FLAG_START && !err_seen) begin
        done_next = 1'b0; // R5 R4
        irq_next  = 1'b0;
      end
    end
    // System reset of the I/O bus
    // Mode drops to one with no checking, and stays there until reloaded
    if (io_system_reset) begin
      mode_next = MEC_MODE_IO_SYSTEM_RESET; // R3
      done_next = 1'b0;
      irq_next  = 1'b0;
    end
    // Enables follow the mode that is about to be registered
    wcc_next = mode_writes(mode_next);
    crd_next = mode_chk_read(mode_next);
    crf_next = mode_chk_ref(mode_next);
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg   <= MEC_MODE_RESET;
      done_reg   <= 1'b0;
      irq_reg    <= 1'b0;
      faddr_reg  <= 20'h00000;
      fsyn_reg   <= 6'h00;
      rdata_reg  <= 16'h0000;
      rval_reg   <= 1'b0;
      wcc_reg    <= 1'b0;
      crd_reg    <= 1'b0;
      crf_reg    <= 1'b0;
      single_reg <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      done_reg   <= done_next;
      irq_reg    <= irq_next;
      faddr_reg  <= faddr_next;
      fsyn_reg   <= fsyn_next;
      rdata_reg  <= rdata_next;
      rval_reg   <= rval_next;
      wcc_reg    <= wcc_next;
      crd_reg    <= crd_next;
      crf_reg    <= crf_next;
      single_reg <= single_next;
    end
  end

  // Outputs straight from flops
  assign io_acc_in        = rdata_reg;
  assign io_acc_valid     = rval_reg;
  assign done_flag        = done_reg;
  assign int_request      = irq_reg;
  assign write_checkcode  = wcc_reg;
  assign check_on_read    = crd_reg;
  assign check_on_refresh = crf_reg;
  assign syn_single_bit   = single_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_start_cmd;
    hit && io_flag_cmd == MEC_FLAG_START && !err_seen && !io_system_reset;
  endsequence

  chk_reset_clears: assert property ( // R3
    @(posedge core_clk) disable iff (rst)
    io_system_reset |=> !done_reg && !irq_reg && !crd_reg && !crf_reg)
    else $error("reset did not clear flags");

  chk_start_clears: assert property ( // R5
    @(posedge core_clk) disable iff (rst)
    s_start_cmd |=> !done_reg && !irq_reg)
    else $error("start did not clear flags");

  chk_other_code: assert property ( // R1
    @(posedge core_clk) disable iff (rst)
    io_strobe && io_dev_code != MEC_DEV_CODE && !err_seen &&
    !io_system_reset |=> $stable(done_reg) && $stable(mode_reg))
    else $error("foreign device code acted");

  chk_flag_noop: assert property ( // R4
    @(posedge core_clk) disable iff (rst)
    hit && io_flag_cmd != MEC_FLAG_START && !err_seen &&
    !io_system_reset |=> $stable(done_reg) && $stable(irq_reg))
    else $error("inert flag command changed flags");

  chk_read_low: assert property ( // R6
    @(posedge core_clk) disable iff (rst)
    hit && io_xfer == MEC_XFER_IN_A |=>
    io_acc_valid && io_acc_in == $past(faddr_reg[15:0]))
    else $error("low address read wrong");

  chk_read_code: assert property ( // R8
    @(posedge core_clk) disable iff (rst)
    hit && io_xfer == MEC_XFER_IN_B |=>
    io_acc_valid && io_acc_in[9:4] == 6'h00 &&
    io_acc_in[15:10] == $past(fsyn_reg) &&
    io_acc_in[3:0] == $past(faddr_reg[19:16]))
    else $error("fault code word wrong");

  chk_zero_syn: assert property ( // R9
    @(posedge core_clk) disable iff (rst)
    chk_error && chk_syndrome == 6'h00 && !io_system_reset |=>
    $stable(fsyn_reg) && $stable(faddr_reg))
    else $error("zero syndrome was captured");

  chk_mode_load: assert property ( // R11
    @(posedge core_clk) disable iff (rst)
    hit && io_xfer == MEC_XFER_OUT_A && !io_system_reset |=>
    mode_reg == $past(io_acc_out[2:0]) &&
    check_on_read == $past(io_acc_out[1]) &&
    check_on_refresh == !$past(io_acc_out[2]))
    else $error("mode decode wrong");

  chk_irq_gate: assert property ( // R14 R2
    @(posedge core_clk) disable iff (rst)
    err_seen && !io_system_reset |=>
    done_reg && irq_reg == ($past(irq_reg) || $past(mode_reg) == 3'h3 ||
    $past(mode_reg) == 3'h7))
    else $error("error capture wrong");

endmodule : memory_error_corrector

// file: tb/mec_host_model.sv
// Host side: issues programmed I/O instructions toward the unit
module mec_host_model
  import mec_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Instruction lines toward the unit
  output logic             io_strobe,
  output logic [5:0]       io_dev_code,
  output logic [2:0]       io_xfer,
  output logic [1:0]       io_flag_cmd,
  output logic [15:0]      io_acc_out,
  output logic [15:0]      io_prio_mask,
  // Read data back from the unit
  input  wire logic [15:0] io_acc_in,
  input  wire logic        io_acc_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle lines; every mask bit set, which must not block the unit
  initial begin
    io_strobe    = 1'b0;
    io_dev_code  = 6'h00;
    io_xfer      = 3'h0;
    io_flag_cmd  = 2'h0;
    io_acc_out   = 16'h0000;
    io_prio_mask = 16'hFFFF;
  end

  // One instruction: a one-cycle strobe, lines launched at the falling edge
  task automatic pio(input logic [5:0] dev, input logic [2:0] xf,
                     input logic [1:0] fl, input logic [15:0] acc);
    @(negedge core_clk);
    io_strobe   = 1'b1;
    io_dev_code = dev;
    io_xfer     = xf;
    io_flag_cmd = fl;
    io_acc_out  = acc;
    @(negedge core_clk);
    io_strobe   = 1'b0;
    // Released lines show the inverse so stale values cannot pass
    io_dev_code = ~dev;
    io_xfer     = ~xf;
    io_flag_cmd = ~fl;
    io_acc_out  = ~acc;
  endtask : pio

  // Input transfer; caller reads only while Done is set
  task automatic rd(input logic [2:0] xf, input logic [1:0] fl,
                    output logic [15:0] data);
    int n;
    data = 16'hDEAD;
    pio(MEC_DEV_CODE, xf, fl, 16'h0000);
    // Bounded wait for the one-cycle valid pulse
    for (n = 0; n < 4; n++) begin
      if (io_acc_valid === 1'b1) begin
        data = io_acc_in;
        break;
      end
      @(negedge core_clk);
    end
  endtask : rd
endmodule : mec_host_model

// file: tb/memory_error_corrector_tb.sv
// Self-checking bench for the error correction control unit
module memory_error_corrector_tb
  import mec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk, rst, io_system_reset;      // Clock and resets
  logic        io_strobe, chk_error, chk_is_refresh; // Strobes
  logic [5:0]  io_dev_code, chk_syndrome;           // Codes
  logic [2:0]  io_xfer;                             // Transfer select
  logic [1:0]  io_flag_cmd;                         // Flag command
  logic [15:0] io_acc_out, io_prio_mask, io_acc_in; // Data words
  logic [19:0] chk_address;                         // Fault address
  logic        io_acc_valid, done_flag, int_request;
  logic        write_checkcode, check_on_read, check_on_refresh;
  logic        syn_single_bit;
  int          n_errors, n_tests, cyc;              // Bookkeeping
  logic [15:0] d;                                   // Read-back word

  memory_error_corrector memory_error_corrector_inst (.*);
  mec_host_model mec_host_model_inst (.*);

  ////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period; hang guard well above the expected run length
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Flags and enables packed as {done, irq, single, wr, rd, ref}
  function automatic logic [15:0] st();
    return {10'h000, done_flag, int_request, syn_single_bit,
            write_checkcode, check_on_read, check_on_refresh};
  endfunction : st

  // Checker report pulse; address and syndrome lines inverted afterwards
  task automatic err(input logic [19:0] a, input logic [5:0] s,
                     input logic refr);
    @(negedge core_clk);
    chk_error = 1'b1;
    chk_address = a;
    chk_syndrome = s;
    chk_is_refresh = refr;
    @(negedge core_clk);
    chk_error = 1'b0;
    chk_address = ~a;
    chk_syndrome = ~s;
    @(negedge core_clk);
  endtask : err

  task automatic mode(input logic [2:0] m);
    // Ignored upper bits carry ones on purpose
    mec_host_model_inst.pio(MEC_DEV_CODE, MEC_XFER_OUT_A, 2'h0, {13'h1FFF, m});
    @(negedge core_clk);
  endtask : mode

  ////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    logic [2:0] m;
    chk(st(), 16'h0005);
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      mode(m);
      chk(st(), {13'h0, m[1:0] != 2'h1, m[1], ~m[2]});
    end
  endtask : t_modes

  // Fault with interrupts on, read-back, inert commands, start
  task automatic t_fault();
    mode(3'h3);
    err(20'hA5C3E, 6'h1C, 1'b0);
    chk(st(), 16'h003F);
    mec_host_model_inst.rd(MEC_XFER_IN_A, 2'h0, d);
    chk(d, 16'h5C3E);
    mec_host_model_inst.pio(6'h03, MEC_XFER_OUT_A, 2'h1, 16'h0000);
    mec_host_model_inst.pio(MEC_DEV_CODE, 3'h0, 2'h2, 16'h0000);
    mec_host_model_inst.pio(MEC_DEV_CODE, 3'h0, 2'h3, 16'h0000);
    @(negedge core_clk);
    chk(st(), 16'h003F);
    mec_host_model_inst.rd(MEC_XFER_IN_B, 2'h1, d);
    chk(d, 16'h700A);
    @(negedge core_clk);
    chk(st(), 16'h000F);
    // A report with an all-zero syndrome is no error
    err(20'h00005, 6'h00, 1'b0);
    chk(st(), 16'h000F);
  endtask : t_fault

  // Interrupt gating by mode, ignored checks, system I/O reset
  task automatic t_gating();
    mode(3'h2);
    err(20'h00001, 6'h01, 1'b0);
    chk(st(), 16'h002F);
    mec_host_model_inst.pio(MEC_DEV_CODE, 3'h0, 2'h1, 16'h0000);
    mode(3'h6);
    err(20'h00002, 6'h01, 1'b1);
    chk(st(), 16'h000E);
    mode(3'h4);
    err(20'h00003, 6'h07, 1'b0);
    chk(st(), 16'h000C);
    mode(3'h7);
    err(20'h00004, 6'h07, 1'b0);
    chk(st(), 16'h0036);
    io_system_reset = 1'b1;
    @(negedge core_clk);
    io_system_reset = 1'b0;
    @(negedge core_clk);
    chk(st(), 16'h0004);
  endtask : t_gating

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // Main sequence: reset held 16 cycles, then each scenario
  initial begin
    rst = 1'b1;
    io_system_reset = 1'b0;
    chk_error = 1'b0;
    chk_is_refresh = 1'b0;
    chk_address = 20'h00000;
    chk_syndrome = 6'h00;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    t_modes();
    t_fault();
    t_gating();
    summarize();
  end
endmodule : memory_error_corrector_tb
